// ---- design/psc_map.svh ----
// psc_map.svh: offsets, field positions, reset values and timing figures of the
// power-save and function-switch controller.
// assumes: included by bare name by the design files of this block.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// clock rate and timing figures
`define PSC_CLK_HZ 40000000
`define PSC_STOP_HOLD_MS 5000
`define PSC_RUN_HOLD_MS 2000
`define PSC_RANGING_RESUME_MS 200
`define PSC_MOTOR_RESUME_MS 3000
`define PSC_MS_TO_CYC(ms) (((ms) * 64'd40000) / 64'd1)

// register word offsets (byte addresses)
`define PSC_OFS_COMMAND 8'h00
`define PSC_OFS_SWITCH 8'h04
`define PSC_OFS_CONFIG 8'h08
`define PSC_OFS_STATUS 8'h0C
`define PSC_OFS_ALARM_IN 8'h10

// command register fields
`define PSC_CMD_CODE_LSB 8
`define PSC_CMD_CODE_MSB 15
`define PSC_CMD_DATA_LSB 0
`define PSC_CMD_DATA_MSB 7

// command codes (coined)
`define PSC_CODE_RANGING 8'h01
`define PSC_CODE_MOTOR 8'h02
`define PSC_CODE_REBOOT 8'h03
`define PSC_CODE_PARTICLE 8'h04
`define PSC_CODE_OUT_MODE 8'h05
`define PSC_CODE_SPATIAL 8'h06
`define PSC_CODE_FOG 8'h07

// switch register bits
`define PSC_SW_PARTICLE 0
`define PSC_SW_STATIC 1
`define PSC_SW_SPATIAL 2
`define PSC_SW_FOG 3

// config register bits
`define PSC_CFG_RANGING_IN_EN 0
`define PSC_CFG_MOTOR_IN_EN 1
`define PSC_CFG_READY_OUT_EN 2
`define PSC_CFG_ASSOC_LSB 8
`define PSC_CFG_ASSOC_MSB 15

// alarm bit positions (self-test items)
`define PSC_ALM_INTERNAL 0
`define PSC_ALM_MOTOR 3
`define PSC_ALM_RANGING 5
`define PSC_ALM_FOG 7
`define PSC_ALM_W 8

// stored configuration defaults (restored at every restart)
`define PSC_CFG_RESET 16'h0907
`define PSC_SW_RESET 4'h0

`define PSC_RDATA_UNMAPPED 32'hDEAD_BEEF

`endif

// ---- design/psc_pkg.sv ----
// psc_pkg.sv: types shared by the power-save controller files.
// assumes: compiled before the modules.
package psc_pkg;
  typedef enum logic [1:0] {PSC_RUN, PSC_STOPPED, PSC_RESUMING} psc_phase_t;
endpackage

// ---- design/psc_hold_qual.sv ----
// psc_hold_qual.sv: qualifies a pin level held for a stop time or a run time.
// assumes: pin is asynchronous; one clock domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module psc_hold_qual #(
  parameter int CNT_W = 28,
  parameter logic [CNT_W-1:0] STOP_CYC = 28'd200000000,
  parameter logic [CNT_W-1:0] RUN_CYC = 28'd80000000
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic stop_pulse_out,
  output logic run_pulse_out
);
  logic [2:0] sync_reg;
  logic level_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic fired_reg;

  // three flops; a change counts when the second and third agree
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_in};
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
    end
  end

  // counter restarts on any level change; one pulse per qualified hold
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
      fired_reg <= 1'b0;
      stop_pulse_out <= 1'b0;
      run_pulse_out <= 1'b0;
    end else begin
      stop_pulse_out <= 1'b0;
      run_pulse_out <= 1'b0;
      if ((sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg)) begin
        cnt_reg <= '0;
        fired_reg <= 1'b0;
      end else if (!fired_reg) begin
        if (cnt_reg == (level_reg ? STOP_CYC : RUN_CYC) - 1'b1) begin
          fired_reg <= 1'b1;
          stop_pulse_out <= level_reg;
          run_pulse_out <= !level_reg;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule // psc_hold_qual
`default_nettype wire

// ---- design/psc_ctrl.sv ----
// psc_ctrl.sv: power-save and function-switch controller with Avalon-MM slave.
// assumes: host packets arrive as writes to the command register; alarm
// sources other than the two stop alarms come in as levels on the same clock.
//
// How it works
// - ranging command data 0 stops laser ranging, data 1 resumes it.
// - ranging pin high for 5 s stops ranging.
// - ranging pin low for 2 s releases the ranging stop.
// - motor command data 0 halts the motor, data 1 restarts it.
// - motor pin high for 5 s stops the motor.
// - motor pin low for 2 s restarts the motor.
// - ranging stop raises its alarm, lights fault led, may drop ready.
// - motor stop raises its alarm, lights fault led, drops ready by default.
// - ranging resumes 200 ms after the release is qualified.
// - ranging returns 3 s after the motor restart is qualified.
// - each pin acts only when its enable bit is set.
// - reboot command restarts the block except the two pin qualifiers.
// - ranging is stopped whenever the motor is stopped.
// - a command switches the particle filter on or off.
// - a command selects static (filtered) or mobile (raw) output.
// - a command switches the spatial filter on or off.
// - a command switches fog detection; fog alarm only while enabled.
// - output mode defaults to mobile.
// - switches last until restart, then take stored configuration values.
// - ready is valid only when no associated alarm is active.
// - ready pin is on when ready is valid and its output is enabled.
// - status word carries ready in bit 0, alarm items above it.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_ctrl #(
  parameter logic [27:0] STOP_HOLD_CYC = 28'd200000000,
  parameter logic [27:0] RUN_HOLD_CYC = 28'd80000000,
  parameter logic [27:0] RANGING_RESUME_CYC = 28'd8000000,
  parameter logic [27:0] MOTOR_RESUME_CYC = 28'd120000000
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ranging_ctrl_input_in,
  input wire logic motor_ctrl_input_in,
  input wire logic fog_seen_in,
  input wire logic internal_err_in,
  output logic laser_enable_out,
  output logic motor_enable_out,
  output logic ranging_valid_out,
  output logic fault_led_out,
  output logic ready_output_pin_out,
  output logic particle_filter_out,
  output logic static_mode_out,
  output logic spatial_filter_out,
  output logic fog_detect_out
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic reboot_reg;
  logic ack_reg;
  logic [15:0] cfg_reg;
  logic [3:0] sw_reg;
  logic [`PSC_ALM_W-1:0] alarm_reg;
  logic ready_reg;
  logic [15:0] last_cmd_reg;
  psc_pkg::psc_phase_t rng_phase_reg;
  psc_pkg::psc_phase_t mot_phase_reg;
  logic [27:0] rng_cnt_reg;
  logic [27:0] mot_cnt_reg;

  logic req;
  logic wr_cmd;
  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic rng_stop_pin;
  logic rng_run_pin;
  logic mot_stop_pin;
  logic mot_run_pin;
  logic rng_stop_ev;
  logic rng_run_ev;
  logic mot_stop_ev;
  logic mot_run_ev;

  // one wait cycle, answered at the second edge of the request
  assign req = (avs_read_in || avs_write_in) && !ack_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end
  // waitrequest is a flop of its own, always the inverse of ack_reg
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !req;
    end
  end

  // a command needs both low lanes: code and data travel together
  assign wr_cmd = avs_write_in && ack_reg && (avs_address_in == `PSC_OFS_COMMAND)
    && avs_byteenable_in[0] && avs_byteenable_in[1];
  assign cmd_code = avs_writedata_in[`PSC_CMD_CODE_MSB:`PSC_CMD_CODE_LSB];
  assign cmd_data = avs_writedata_in[`PSC_CMD_DATA_MSB:`PSC_CMD_DATA_LSB];

  // read data is launched at the request's first edge and stands at the
  // edge where waitrequest is sampled low
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (req && avs_read_in) begin
      case (avs_address_in)
        `PSC_OFS_COMMAND: avs_readdata_out <= {16'h0000, last_cmd_reg};
        `PSC_OFS_SWITCH: avs_readdata_out <= {28'h0000000, sw_reg};
        `PSC_OFS_CONFIG: avs_readdata_out <= {16'h0000, cfg_reg};
        `PSC_OFS_STATUS: avs_readdata_out <= {23'h0, alarm_reg, ready_reg};
        `PSC_OFS_ALARM_IN: avs_readdata_out <= {26'h0, rng_phase_reg, mot_phase_reg,
          fog_seen_in, internal_err_in};
        default: avs_readdata_out <= `PSC_RDATA_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command and configuration registers
  // ----------------------------------------------------------------
  // reboot is a one-clock pulse that takes the place of rst_in below, except at the two pin qualifiers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      reboot_reg <= 1'b0;
      last_cmd_reg <= 16'h0000;
    end else begin
      reboot_reg <= wr_cmd && (cmd_code == `PSC_CODE_REBOOT);
      if (wr_cmd) begin
        last_cmd_reg <= avs_writedata_in[`PSC_CMD_CODE_MSB:`PSC_CMD_DATA_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      cfg_reg <= `PSC_CFG_RESET;
    end else if (avs_write_in && ack_reg && (avs_address_in == `PSC_OFS_CONFIG)) begin
      // one lane per byte; lanes 2 and 3 hold nothing
      if (avs_byteenable_in[0]) begin
        cfg_reg[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        cfg_reg[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // switches return to stored values on every restart
  // unknown codes leave every switch as it was
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      sw_reg <= `PSC_SW_RESET;
    end else if (wr_cmd) begin
      case (cmd_code)
        `PSC_CODE_PARTICLE: sw_reg[`PSC_SW_PARTICLE] <= cmd_data[0];
        `PSC_CODE_OUT_MODE: sw_reg[`PSC_SW_STATIC] <= cmd_data[0];
        `PSC_CODE_SPATIAL: sw_reg[`PSC_SW_SPATIAL] <= cmd_data[0];
        `PSC_CODE_FOG: sw_reg[`PSC_SW_FOG] <= cmd_data[0];
        default: sw_reg <= sw_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin qualification
  // ----------------------------------------------------------------
  // qualifiers sit outside the reboot reset: a pin held across a reboot
  // keeps its count, so the host need not restart its hold
  psc_hold_qual #(
    .CNT_W(28),
    .STOP_CYC(STOP_HOLD_CYC),
    .RUN_CYC(RUN_HOLD_CYC)
  ) u_rng_qual (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in(ranging_ctrl_input_in),
    .stop_pulse_out(rng_stop_pin),
    .run_pulse_out(rng_run_pin)
  );

  psc_hold_qual #(
    .CNT_W(28),
    .STOP_CYC(STOP_HOLD_CYC),
    .RUN_CYC(RUN_HOLD_CYC)
  ) u_mot_qual (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in(motor_ctrl_input_in),
    .stop_pulse_out(mot_stop_pin),
    .run_pulse_out(mot_run_pin)
  );

  // either path acts; a pin only when enabled
  // a pin event with its enable clear is dropped, not remembered
  assign rng_stop_ev = (wr_cmd && (cmd_code == `PSC_CODE_RANGING) && (cmd_data == 8'h00))
    || (rng_stop_pin && cfg_reg[`PSC_CFG_RANGING_IN_EN]);
  assign rng_run_ev = (wr_cmd && (cmd_code == `PSC_CODE_RANGING) && (cmd_data == 8'h01))
    || (rng_run_pin && cfg_reg[`PSC_CFG_RANGING_IN_EN]);
  assign mot_stop_ev = (wr_cmd && (cmd_code == `PSC_CODE_MOTOR) && (cmd_data == 8'h00))
    || (mot_stop_pin && cfg_reg[`PSC_CFG_MOTOR_IN_EN]);
  assign mot_run_ev = (wr_cmd && (cmd_code == `PSC_CODE_MOTOR) && (cmd_data == 8'h01))
    || (mot_run_pin && cfg_reg[`PSC_CFG_MOTOR_IN_EN]);

  // ----------------------------------------------------------------
  // ranging stop state
  // ----------------------------------------------------------------
  // stop wins over run in one cycle; a stop while resuming stops again
  // and the resume delay starts over from zero
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      rng_phase_reg <= psc_pkg::PSC_RUN;
      rng_cnt_reg <= 28'h0000000;
    end else if (rng_stop_ev) begin
      rng_phase_reg <= psc_pkg::PSC_STOPPED;
    end else begin
      case (rng_phase_reg)
        psc_pkg::PSC_STOPPED: begin
          if (rng_run_ev) begin
            rng_phase_reg <= psc_pkg::PSC_RESUMING;
            rng_cnt_reg <= 28'h0000000;
          end
        end
        psc_pkg::PSC_RESUMING: begin
          if (rng_cnt_reg == RANGING_RESUME_CYC - 28'h0000001) begin
            rng_phase_reg <= psc_pkg::PSC_RUN;
          end else begin
            rng_cnt_reg <= rng_cnt_reg + 28'h0000001;
          end
        end
        psc_pkg::PSC_RUN: rng_phase_reg <= psc_pkg::PSC_RUN;
        default: rng_phase_reg <= psc_pkg::PSC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // motor stop state
  // ----------------------------------------------------------------
  // same phases as ranging; the motor phase also gates the laser
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      mot_phase_reg <= psc_pkg::PSC_RUN;
      mot_cnt_reg <= 28'h0000000;
    end else if (mot_stop_ev) begin
      mot_phase_reg <= psc_pkg::PSC_STOPPED;
    end else begin
      case (mot_phase_reg)
        psc_pkg::PSC_STOPPED: begin
          if (mot_run_ev) begin
            mot_phase_reg <= psc_pkg::PSC_RESUMING;
            mot_cnt_reg <= 28'h0000000;
          end
        end
        psc_pkg::PSC_RESUMING: begin
          if (mot_cnt_reg == MOTOR_RESUME_CYC - 28'h0000001) begin
            mot_phase_reg <= psc_pkg::PSC_RUN;
          end else begin
            mot_cnt_reg <= mot_cnt_reg + 28'h0000001;
          end
        end
        psc_pkg::PSC_RUN: mot_phase_reg <= psc_pkg::PSC_RUN;
        default: mot_phase_reg <= psc_pkg::PSC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alarms, ready and outputs
  // ----------------------------------------------------------------
  // one bit per self-test item; items this block does not own stay clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      alarm_reg <= '0;
    end else begin
      alarm_reg <= '0;
      alarm_reg[`PSC_ALM_INTERNAL] <= internal_err_in;
      alarm_reg[`PSC_ALM_MOTOR] <= (mot_phase_reg == psc_pkg::PSC_STOPPED);
      alarm_reg[`PSC_ALM_RANGING] <= (rng_phase_reg == psc_pkg::PSC_STOPPED);
      alarm_reg[`PSC_ALM_FOG] <= fog_seen_in && sw_reg[`PSC_SW_FOG];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      ready_reg <= 1'b0;
      fault_led_out <= 1'b0;
    end else begin
      ready_reg <= ~|(alarm_reg & cfg_reg[`PSC_CFG_ASSOC_MSB:`PSC_CFG_ASSOC_LSB]);
      fault_led_out <= |alarm_reg;
    end
  end

  // the pin lags ready_reg by one clock, so a mask write never glitches it
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      ready_output_pin_out <= 1'b0;
    end else begin
      ready_output_pin_out <= ready_reg && cfg_reg[`PSC_CFG_READY_OUT_EN];
    end
  end

  // the laser needs both phases out of stop; valid needs both fully run
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      laser_enable_out <= 1'b1;
      motor_enable_out <= 1'b1;
      ranging_valid_out <= 1'b0;
    end else begin
      motor_enable_out <= (mot_phase_reg != psc_pkg::PSC_STOPPED);
      laser_enable_out <= (rng_phase_reg != psc_pkg::PSC_STOPPED)
        && (mot_phase_reg != psc_pkg::PSC_STOPPED);
      ranging_valid_out <= (rng_phase_reg == psc_pkg::PSC_RUN)
        && (mot_phase_reg == psc_pkg::PSC_RUN);
    end
  end

  // function switches drive the data path filters directly
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || reboot_reg) begin
      particle_filter_out <= 1'b0;
      static_mode_out <= 1'b0;
      spatial_filter_out <= 1'b0;
      fog_detect_out <= 1'b0;
    end else begin
      particle_filter_out <= sw_reg[`PSC_SW_PARTICLE];
      static_mode_out <= sw_reg[`PSC_SW_STATIC];
      spatial_filter_out <= sw_reg[`PSC_SW_SPATIAL];
      fog_detect_out <= sw_reg[`PSC_SW_FOG];
    end
  end
endmodule // psc_ctrl
`default_nettype wire

// ---- tb/psc_ctrl_properties.sv ----
// psc_ctrl_properties.sv: concurrent checks on the controller's top-level ports.
// assumes: bound to every psc_ctrl instance; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl_properties (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic laser_enable_out,
  input wire logic motor_enable_out,
  input wire logic ranging_valid_out,
  input wire logic fault_led_out,
  input wire logic ready_output_pin_out,
  input wire logic particle_filter_out,
  input wire logic static_mode_out
);
  // ----------------------------------------
  // restart values, command completions and their effects
  // ----------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  logic cmd_done;
  assign cmd_done = avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00
    && avs_byteenable_in[1:0] == 2'h3;

  AST_RESET_SWITCHES: assert property (rst_in |=> !static_mode_out && !particle_filter_out)
    else $error("switches not at stored values after restart");
  AST_PARTICLE_CMD: assert property (disable iff (rst_in)
    cmd_done && avs_writedata_in[15:0] == 16'h0401 |-> ##[1:3] particle_filter_out)
    else $error("particle filter switch command ignored");
  AST_STATIC_CMD: assert property (disable iff (rst_in)
    cmd_done && avs_writedata_in[15:0] == 16'h0501 |-> ##[1:3] static_mode_out)
    else $error("output mode switch command ignored");
  AST_LASER_OFF_CMD: assert property (disable iff (rst_in)
    cmd_done && avs_writedata_in[15:0] == 16'h0100 |-> ##[1:4] !laser_enable_out)
    else $error("ranging stop command left the laser on");
  AST_MOTOR_CMD: assert property (disable iff (rst_in)
    cmd_done && avs_writedata_in[15:0] == 16'h0200 |-> ##[1:4] !motor_enable_out)
    else $error("motor stop command left the motor running");
  AST_MOTOR_GATES: assert property (disable iff (rst_in)
    $fell(motor_enable_out) |-> ##[0:2] (!laser_enable_out && !ranging_valid_out))
    else $error("ranging continued with the motor stopped");
  AST_FAULT_LED: assert property (disable iff (rst_in)
    $fell(motor_enable_out) |-> ##[0:3] fault_led_out)
    else $error("fault led not lit on motor stop");
  AST_READY_FALLS: assert property (disable iff (rst_in)
    $fell(motor_enable_out) |-> ##[0:5] !ready_output_pin_out)
    else $error("ready pin stayed on with motor alarm");
  AST_NO_EARLY_RESUME: assert property (disable iff (rst_in)
    $rose(motor_enable_out) |-> !ranging_valid_out [*8])
    else $error("ranging valid too soon after motor restart");
endmodule // psc_ctrl_properties

bind psc_ctrl psc_ctrl_properties i_psc_ctrl_properties (.*);
`default_nettype wire

// ---- tb/psc_host_pins.sv ----
// psc_host_pins.sv: host-side model driving the two discrete stop pins.
// assumes: the bench calls hold() from one thread; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module psc_host_pins (
  input wire logic sys_clk_in,
  output logic ranging_pin_out,
  output logic motor_pin_out
);
  initial begin
    ranging_pin_out = 1'b0;
    motor_pin_out = 1'b0;
  end
  // high asks for a stop, low for a run; level then held for a number of clocks
  task automatic hold(input logic motor_sel, input logic level, input int cycles);
    @(posedge sys_clk_in);
    if (motor_sel) motor_pin_out <= level;
    else ranging_pin_out <= level;
    repeat (cycles) @(posedge sys_clk_in);
  endtask
endmodule // psc_host_pins
`default_nettype wire

// ---- tb/tb.sv ----
// tb.sv: self-checking bench for the power-save and function-switch controller.
// assumes: short hold and resume counts; host pins come from psc_host_pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int STOP = 50, RUN = 20, RRES = 10, MRES = 30;
  logic sys_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fog = 1'b0, ierr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic wait_o, laser, motor, rvalid, led, ready, part, stat, spat, fogd, rpin, mpin;
  int failures = 0, n_compared = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;

  psc_ctrl #(.STOP_HOLD_CYC(28'd50), .RUN_HOLD_CYC(28'd20), .RANGING_RESUME_CYC(28'd10),
    .MOTOR_RESUME_CYC(28'd30)) i_psc_ctrl (.sys_clk_in(sys_clk), .rst_in(rst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .ranging_ctrl_input_in(rpin), .motor_ctrl_input_in(mpin), .fog_seen_in(fog),
    .internal_err_in(ierr), .laser_enable_out(laser), .motor_enable_out(motor),
    .ranging_valid_out(rvalid), .fault_led_out(led), .ready_output_pin_out(ready),
    .particle_filter_out(part), .static_mode_out(stat), .spatial_filter_out(spat),
    .fog_detect_out(fogd));
  psc_host_pins i_psc_host_pins (.sys_clk_in(sys_clk), .ranging_pin_out(rpin),
    .motor_pin_out(mpin));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge sys_clk); while (wait_o !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] data);
    bus(1'b1, 8'h00, {16'h0000, code, data});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("static_mode", 32'h0, stat);
    check("switch_pins", 32'h0, {part, spat, fogd});
    bus(1'b0, 8'h08, 32'h0);
    check("config", 32'h0000_0907, rv);
    bus(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'hDEAD_BEEF, rv);
    bus(1'b0, 8'h0C, 32'h0);
    check("status", 32'h0000_0001, rv);
    check("ready_pin", 32'h1, ready);
  endtask
  task automatic t_switches();
    for (int i = 0; i < 4; i++) begin
      cmd(8'h04 + 8'(i), 8'h01);
      bus(1'b0, 8'h04, 32'h0);
      check("switch_reg", (32'h2 << i) - 32'h1, rv);
    end
    check("switch_pins", 32'hF, {fogd, spat, stat, part});
    fog <= 1'b1;
    settle(5);
    bus(1'b0, 8'h0C, 32'h0);
    check("fog_status", 32'h0000_0101, rv);
    cmd(8'h07, 8'h00);
    settle(5);
    bus(1'b0, 8'h0C, 32'h0);
    check("fog_off_status", 32'h0000_0001, rv);
    fog <= 1'b0;
    ierr <= 1'b1;
    settle(8);
    check("ready_internal", 32'h0, ready);
    @(posedge sys_clk);
    ierr <= 1'b0;
    cmd(8'h05, 8'h00);
    settle(8);
    check("mobile_mode", 32'h0, stat);
  endtask
  task automatic t_motor_cmd();
    cmd(8'h02, 8'h00);
    settle(6);
    check("motor_stop", 32'h0, {motor, laser});
    check("motor_led_ready", 32'h2, {led, ready});
    bus(1'b0, 8'h0C, 32'h0);
    check("motor_status", 32'h0000_0010, rv);
    cmd(8'h02, 8'h01);
    settle(MRES / 2);
    check("motor_resume_early", 32'h0, rvalid);
    settle(MRES);
    check("motor_resumed", 32'h1F, {rvalid, motor, laser, !led, ready});
  endtask
  task automatic t_ranging_cmd();
    cmd(8'h01, 8'h00);
    settle(6);
    check("ranging_stop", 32'h3, {laser, led, ready});
    bus(1'b0, 8'h0C, 32'h0);
    check("ranging_status", 32'h0000_0041, rv);
    cmd(8'h01, 8'h01);
    settle(RRES / 2);
    check("ranging_resume_early", 32'h0, rvalid);
    settle(RRES + 6);
    check("ranging_resumed", 32'h3, {rvalid, laser});
  endtask
  task automatic t_pins();
    i_psc_host_pins.hold(1'b1, 1'b1, STOP - 10);
    i_psc_host_pins.hold(1'b1, 1'b0, RUN + 10);
    check("short_high", 32'h1, motor);
    i_psc_host_pins.hold(1'b1, 1'b1, STOP + 10);
    check("motor_pin_stop", 32'h0, motor);
    i_psc_host_pins.hold(1'b1, 1'b0, RUN - 5);
    check("short_low", 32'h0, motor);
    i_psc_host_pins.hold(1'b1, 1'b0, RUN + 10);
    check("motor_pin_run", 32'h1, motor);
    settle(MRES + 5);
    i_psc_host_pins.hold(1'b0, 1'b1, STOP + 10);
    check("ranging_pin_stop", 32'h0, laser);
    i_psc_host_pins.hold(1'b0, 1'b0, 2);
    cmd(8'h01, 8'h01);
    settle(RRES + 6);
    check("packet_clears_pin", 32'h3, {laser, rvalid});
    i_psc_host_pins.hold(1'b0, 1'b1, STOP + 10);
    i_psc_host_pins.hold(1'b0, 1'b0, RUN + RRES + 10);
    check("ranging_pin_run", 32'h3, {laser, rvalid});
    bus(1'b1, 8'h08, 32'h0000_0904);
    i_psc_host_pins.hold(1'b1, 1'b1, STOP + 10);
    check("pin_disabled", 32'h1, motor);
    i_psc_host_pins.hold(1'b1, 1'b0, 2);
  endtask
  task automatic t_reboot();
    cmd(8'h04, 8'h01);
    settle(3);
    check("particle_on", 32'h1, part);
    @(posedge sys_clk);
    be <= 4'h1;
    cmd(8'h04, 8'h00);
    be <= 4'hF;
    settle(3);
    check("half_cmd_refused", 32'h1, part);
    bus(1'b1, 8'h08, 32'h0000_0900);
    settle(3);
    check("ready_out_off", 32'h0, ready);
    cmd(8'h03, 8'h00);
    settle(4);
    check("reboot_switch", 32'h0, part);
    check("reboot_ready", 32'h1, ready);
    bus(1'b0, 8'h08, 32'h0);
    check("reboot_config", 32'h0000_0907, rv);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    settle(8);
    t_reset();
    t_switches();
    t_motor_cmd();
    t_ranging_cmd();
    t_pins();
    t_reboot();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
